//--- src/sdps_sequencer.sv
// sdram pattern sequencer: steps pattern words in quarter phases and drives the pins
`timescale 1ns/1ps
`default_nettype none
`include "sdps_regs.svh"

// What this block does
// - single read starts at word 0x00, five used
// - single read command leaves row open
// - nop word after activate covers row delay
// - wait word after read covers cas latency
// - single read ends acking with last flag
// - single write starts at word 0x18, four used
// - single write command acks without auto precharge
// - single write ends with precharge, last flag
// - burst read starts 0x08, auto precharge read
// - first four burst acks from repeated word
// - fifth and sixth acks from second word
// - seventh ack negates byte strobes
// - eighth ack word ends burst pattern
// - repeat field executes word one to four times
// - last word applies, then request is done
// - ack bit drives transfer acknowledge that cycle
// - chip select bits map quarter phases 1-4
module sdps_sequencer
	import sdps_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	input wire logic req_valid_i,
	input wire sdps_kind_type req_kind_i,
	input wire logic gp0_default_i,
	input wire sdps_wr_type pat_wr_i,
	output logic chip_select_n_o,
	output logic byte_strobe_n_o,
	output logic transfer_acknowledge_o,
	output logic gp_line0_o,
	output logic [1:0] address_source_select_o,
	output logic next_burst_address_o,
	output logic busy_o,
	output logic done_o
);

	sdps_state_type state_ff, nxt_state;
	logic [5:0] ptr_ff, nxt_ptr;
	logic [1:0] redo_ff, nxt_redo;
	logic [1:0] qph_ff, nxt_qph;
	logic done_ff, nxt_done;
	logic busy_ff;
	logic cs_n_ff, nxt_cs_n;
	logic bs_n_ff, nxt_bs_n;
	logic ack_ff, nxt_ack;
	logic gp0_ff, nxt_gp0;
	logic [1:0] amx_ff, nxt_amx;
	logic na_ff, nxt_na;
	sdps_word_type word;
	logic [1:0] gp_half;

	sdps_pattern_store u_store (
		.sys_clk_i(sys_clk_i),
		.rst_n_i(rst_n_i),
		.ce_i(ce_i),
		.wr_i(pat_wr_i),
		.rd_addr_i(ptr_ff),
		.rd_word_o(word)
	);

	////////////////////////////////////////////////////////////////////////////////
	// sequencing: four sys clocks make one bus clock, one word execution per bus clock

	always_comb begin
		nxt_state = state_ff;
		nxt_ptr = ptr_ff;
		nxt_redo = redo_ff;
		nxt_qph = qph_ff;
		nxt_done = 1'b0;
		case (state_ff)
			SDPS_IDLE: begin
				nxt_qph = `SDPS_QPH_FIRST;
				nxt_redo = 2'h0;
				// an undefined kind is ignored rather than running an empty pattern
				if (req_valid_i && req_kind_i != SDPS_KIND_NONE) begin
					nxt_state = SDPS_RUN;
					if (req_kind_i == SDPS_KIND_SREAD) begin
						nxt_ptr = `SDPS_START_SREAD;
					end else if (req_kind_i == SDPS_KIND_BREAD) begin
						nxt_ptr = `SDPS_START_BREAD;
					end else begin
						nxt_ptr = `SDPS_START_SWRITE;
					end
				end
			end
			SDPS_RUN: begin
				nxt_qph = qph_ff + 2'h1;
				if (qph_ff == `SDPS_QPH_LAST) begin
					if (redo_ff != word.repeat_count) begin
						nxt_redo = redo_ff + 2'h1;
					end else if (word.last_word) begin
						nxt_state = SDPS_IDLE;
						nxt_done = 1'b1;
					end else begin
						nxt_ptr = ptr_ff + 6'h01;
						nxt_redo = 2'h0;
					end
				end
			end
			default: begin
				nxt_state = SDPS_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_ff <= SDPS_IDLE;
			ptr_ff <= 6'h00;
			redo_ff <= 2'h0;
			qph_ff <= 2'h0;
			done_ff <= 1'b0;
			busy_ff <= 1'b0;
		end else if (ce_i) begin
			state_ff <= nxt_state;
			ptr_ff <= nxt_ptr;
			redo_ff <= nxt_redo;
			qph_ff <= nxt_qph;
			done_ff <= nxt_done;
			busy_ff <= (nxt_state == SDPS_RUN);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// pin levels: registered, so pins trail the quarter phase by one sys clock

	always_comb begin
		gp_half = qph_ff[1] ? word.gp_line0_second_half : word.gp_line0_first_half;
		nxt_cs_n = 1'b1;
		nxt_bs_n = 1'b1;
		nxt_ack = 1'b0;
		nxt_gp0 = gp0_default_i;
		nxt_amx = 2'h0;
		nxt_na = 1'b0;
		if (state_ff == SDPS_RUN) begin
			nxt_cs_n = word.cs_level[~qph_ff];
			nxt_bs_n = word.byte_strobe_level[~qph_ff];
			// one ack pulse per execution so repeated words count every beat
			nxt_ack = word.ack_assert_bit && (qph_ff == `SDPS_QPH_FIRST);
			nxt_amx = word.address_source_select;
			nxt_na = word.next_burst_address;
			if (gp_half == `SDPS_GP_DRIVE_LOW) begin
				nxt_gp0 = 1'b0;
			end else if (gp_half == `SDPS_GP_DRIVE_HIGH) begin
				nxt_gp0 = 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cs_n_ff <= 1'b1;
			bs_n_ff <= 1'b1;
			ack_ff <= 1'b0;
			gp0_ff <= 1'b0;
			amx_ff <= 2'h0;
			na_ff <= 1'b0;
		end else if (ce_i) begin
			cs_n_ff <= nxt_cs_n;
			bs_n_ff <= nxt_bs_n;
			ack_ff <= nxt_ack;
			gp0_ff <= nxt_gp0;
			amx_ff <= nxt_amx;
			na_ff <= nxt_na;
		end
	end

	assign chip_select_n_o = cs_n_ff;
	assign byte_strobe_n_o = bs_n_ff;
	assign transfer_acknowledge_o = ack_ff;
	assign gp_line0_o = gp0_ff;
	assign address_source_select_o = amx_ff;
	assign next_burst_address_o = na_ff;
	assign busy_o = busy_ff;
	assign done_o = done_ff;

	////////////////////////////////////////////////////////////////////////////////
	// checks

	AST_SREAD_START: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(ce_i && state_ff == SDPS_IDLE && req_valid_i && req_kind_i == SDPS_KIND_SREAD)
		|=> (ptr_ff == `SDPS_START_SREAD && busy_o)
	) else $error("single read did not start at word 0x00");

	AST_SWRITE_START: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(ce_i && state_ff == SDPS_IDLE && req_valid_i && req_kind_i == SDPS_KIND_SWRITE)
		|=> (ptr_ff == `SDPS_START_SWRITE)
	) else $error("single write did not start at word 0x18");

	AST_BREAD_START: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(ce_i && state_ff == SDPS_IDLE && req_valid_i && req_kind_i == SDPS_KIND_BREAD)
		|=> (ptr_ff == `SDPS_START_BREAD)
	) else $error("burst read did not start at word 0x08");

	AST_LAST_ENDS: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(ce_i && state_ff == SDPS_RUN && qph_ff == `SDPS_QPH_LAST && word.last_word
			&& redo_ff == word.repeat_count)
		|=> (done_o && !busy_o && state_ff == SDPS_IDLE)
	) else $error("last word did not end the pattern");

	AST_STEP_AT_BUS_EDGE: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		// the jump to a routine's start address on a new request is not a step
		(state_ff == SDPS_RUN && $past(state_ff) == SDPS_RUN && $changed(ptr_ff))
		|-> ($past(qph_ff) == `SDPS_QPH_LAST && ptr_ff == $past(ptr_ff) + 6'h01)
	) else $error("word pointer moved off the bus clock boundary");

	AST_REDO_BOUND: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(state_ff == SDPS_RUN) |-> (redo_ff <= word.repeat_count)
	) else $error("repeat count ran past the word's repeat field");

	AST_ACK_FROM_WORD: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		transfer_acknowledge_o |-> ($past(word.ack_assert_bit) && $past(qph_ff) == 2'h0
			&& $past(state_ff) == SDPS_RUN)
	) else $error("transfer acknowledge without the word's ack bit");

	AST_CS_IDLE_HIGH: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(ce_i && state_ff == SDPS_IDLE) |=> chip_select_n_o
	) else $error("chip select driven while idle");

endmodule
`default_nettype wire

//--- src/sdps_regs.svh
// constants of the sdram pattern sequencer: start addresses, pattern words, timing
`ifndef SDPS_REGS_SVH
`define SDPS_REGS_SVH

`define SDPS_START_SREAD 6'h00
`define SDPS_START_BREAD 6'h08
`define SDPS_START_SWRITE 6'h18
`define SDPS_ROUTINE_WORDS 6'h08

`define SDPS_W_ACTIVATE 32'h0F0C_F000
`define SDPS_W_TRCD_NOP 32'hFFFF_F100
`define SDPS_W_SREAD_CMD 32'h00AF_3C00
`define SDPS_W_SREAD_CAS 32'h00F0_F000
`define SDPS_W_SREAD_END 32'hF0FF_FC05
`define SDPS_W_SWRITE_CMD 32'h00A3_3C04
`define SDPS_W_SWRITE_END 32'h00F0_F001
`define SDPS_W_BREAD_CMD 32'h00FF_3C00
`define SDPS_W_BREAD_CAS 32'hF0FF_F000
`define SDPS_W_BREAD_ACK4 32'hF0FF_FF04
`define SDPS_W_BREAD_ACK2 32'hF0FF_FD04
`define SDPS_W_BREAD_ACK7 32'hFFFF_FC04
`define SDPS_W_BREAD_END 32'hFFFF_FC05
`define SDPS_W_EMPTY 32'h0000_0000

`define SDPS_QPH_FIRST 2'h0
`define SDPS_QPH_LAST 2'h3
`define SDPS_GP_DRIVE_LOW 2'h2
`define SDPS_GP_DRIVE_HIGH 2'h3

`endif

//--- src/sdps_pkg.sv
// types of the sdram pattern sequencer
package sdps_pkg;

	typedef enum logic [0:0] {
		SDPS_IDLE = 1'b0,
		SDPS_RUN = 1'b1
	} sdps_state_type;

	typedef enum logic [1:0] {
		SDPS_KIND_SREAD = 2'b00,
		SDPS_KIND_BREAD = 2'b01,
		SDPS_KIND_SWRITE = 2'b10,
		SDPS_KIND_NONE = 2'b11
	} sdps_kind_type;

	// msb first: cs_phase1_level sits in bit 31, last-word flag in bit 0
	typedef struct packed {
		logic [3:0] cs_level;
		logic [3:0] byte_strobe_level;
		logic [1:0] gp_line0_first_half;
		logic [1:0] gp_line0_second_half;
		logic [9:0] gp_other;
		logic [1:0] repeat_count;
		logic loop_mark;
		logic exception_branch_enable;
		logic [1:0] address_source_select;
		logic next_burst_address;
		logic ack_assert_bit;
		logic bank_disable_timer_on;
		logic last_word;
	} sdps_word_type;

	typedef struct packed {
		logic we;
		logic [5:0] addr;
		logic [31:0] data;
	} sdps_wr_type;

endpackage

//--- src/sdps_pattern_store.sv
// pattern store: 64 words of flip-flops preloaded with the recommended routines
`timescale 1ns/1ps
`default_nettype none
`include "sdps_regs.svh"

module sdps_pattern_store
	import sdps_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	input wire sdps_wr_type wr_i,
	input wire logic [5:0] rd_addr_i,
	output sdps_word_type rd_word_o
);

	function automatic logic [31:0] init_word(input logic [5:0] idx);
		logic [31:0] w;
		w = `SDPS_W_EMPTY;
		case (idx)
			6'h00, 6'h08, 6'h18: w = `SDPS_W_ACTIVATE;
			6'h01, 6'h09, 6'h19: w = `SDPS_W_TRCD_NOP;
			6'h02: w = `SDPS_W_SREAD_CMD;
			6'h03: w = `SDPS_W_SREAD_CAS;
			6'h04: w = `SDPS_W_SREAD_END;
			6'h0A: w = `SDPS_W_BREAD_CMD;
			6'h0B: w = `SDPS_W_BREAD_CAS;
			6'h0C: w = `SDPS_W_BREAD_ACK4;
			6'h0D: w = `SDPS_W_BREAD_ACK2;
			6'h0E: w = `SDPS_W_BREAD_ACK7;
			6'h0F: w = `SDPS_W_BREAD_END;
			6'h1A: w = `SDPS_W_SWRITE_CMD;
			6'h1B: w = `SDPS_W_SWRITE_END;
			default: w = `SDPS_W_EMPTY;
		endcase
		return w;
	endfunction

	logic [31:0] mem_ff [64];
	logic [31:0] nxt_mem [64];
	logic written_ff;
	logic nxt_written;

	genvar gi;
	generate
		for (gi = 0; gi < 64; gi++) begin : g_entry
			always_comb begin
				nxt_mem[gi] = mem_ff[gi];
				if (wr_i.we && (wr_i.addr == 6'(gi))) begin
					nxt_mem[gi] = wr_i.data;
				end
			end
			always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					mem_ff[gi] <= init_word(6'(gi));
				end else if (ce_i) begin
					mem_ff[gi] <= nxt_mem[gi];
				end
			end
		end
	endgenerate

	always_comb begin
		nxt_written = written_ff | wr_i.we;
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			written_ff <= 1'b0;
		end else if (ce_i) begin
			written_ff <= nxt_written;
		end
	end

	assign rd_word_o = sdps_word_type'(mem_ff[rd_addr_i]);

	AST_SREAD_CMD_WORD: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(!written_ff && rd_addr_i == 6'h02) |-> (rd_word_o == `SDPS_W_SREAD_CMD)
	) else $error("single read command word is not the preloaded one");

	AST_BREAD_ACK_WORDS: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(!written_ff && rd_addr_i == 6'h0C) |-> (rd_word_o.repeat_count == 2'h3
			&& rd_word_o.ack_assert_bit && !rd_word_o.last_word)
	) else $error("burst read first ack word does not repeat four times");

endmodule
`default_nettype wire

//--- verif/sdps_sdram_model.sv
// memory-side model of the sequencer: counts quarter phases with each pin driven low
`timescale 1ns/1ps
`default_nettype none

module sdps_sdram_model (
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic clr_i,
	input wire logic chip_select_n_i,
	input wire logic byte_strobe_n_i,
	input wire logic gp_line0_i,
	output logic [7:0] cs_lo_o,
	output logic [7:0] bs_lo_o,
	output logic [7:0] gp_lo_o
);
	// the memory sees only pins, so per-pin low counts are what it can judge a pattern by
	always @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cs_lo_o <= 8'h00;
			bs_lo_o <= 8'h00;
			gp_lo_o <= 8'h00;
		end else if (clr_i) begin
			cs_lo_o <= 8'h00;
			bs_lo_o <= 8'h00;
			gp_lo_o <= 8'h00;
		end else begin
			cs_lo_o <= cs_lo_o + {7'h00, chip_select_n_i === 1'b0};
			bs_lo_o <= bs_lo_o + {7'h00, byte_strobe_n_i === 1'b0};
			gp_lo_o <= gp_lo_o + {7'h00, gp_line0_i === 1'b0};
		end
	end
endmodule

`default_nettype wire

//--- verif/test_sdram_pattern_sequencer.sv
// self-checking bench of the sdram pattern sequencer
`timescale 1ns/1ps
`default_nettype none

module test_sdram_pattern_sequencer;
	import sdps_pkg::*;
	logic sys_clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic ce_i = 1'b1;
	logic req_valid_i = 1'b0;
	sdps_kind_type req_kind_i = SDPS_KIND_NONE;
	logic gp0_default_i = 1'b1;
	sdps_wr_type pat_wr_i = '0;
	logic clr = 1'b0;
	logic chip_select_n_o, byte_strobe_n_o, transfer_acknowledge_o, gp_line0_o;
	logic [1:0] address_source_select_o;
	logic next_burst_address_o, busy_o, done_o;
	logic [7:0] cs_lo, bs_lo, gp_lo;
	int error_cnt = 0;
	int comparisons = 0;
	int cyc = 0;

	always #5 sys_clk_i = ~sys_clk_i;

	sdps_sequencer dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
		.req_valid_i(req_valid_i), .req_kind_i(req_kind_i), .gp0_default_i(gp0_default_i),
		.pat_wr_i(pat_wr_i), .chip_select_n_o(chip_select_n_o),
		.byte_strobe_n_o(byte_strobe_n_o), .transfer_acknowledge_o(transfer_acknowledge_o),
		.gp_line0_o(gp_line0_o), .address_source_select_o(address_source_select_o),
		.next_burst_address_o(next_burst_address_o), .busy_o(busy_o), .done_o(done_o));

	sdps_sdram_model mem (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .clr_i(clr),
		.chip_select_n_i(chip_select_n_o), .byte_strobe_n_i(byte_strobe_n_o),
		.gp_line0_i(gp_line0_o), .cs_lo_o(cs_lo), .bs_lo_o(bs_lo), .gp_lo_o(gp_lo));

	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// longest pattern is 52 cycles; the whole run needs well under a thousand
	always @(posedge sys_clk_i) begin
		cyc++;
		if (cyc == 3000) begin
			error_cnt++;
			print_verdict();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// one request; fz > 0 drops ce_i for 3 cycles in the nop word, stretching the run
	task automatic run_pat(input string nm, input sdps_kind_type k, input int len,
		input int acks, input int ack1, input int cs, input int bs, input int gp, input int fz);
		int t;
		int na;
		int fa;
		int la;
		int am;
		t = 0;
		na = 0;
		fa = 0;
		la = 0;
		am = 0;
		@(posedge sys_clk_i);
		#1;
		clr = 1'b1;
		req_kind_i = k;
		req_valid_i = 1'b1;
		@(posedge sys_clk_i);
		#1;
		clr = 1'b0;
		while (done_o !== 1'b1 && t < 200) begin
			@(posedge sys_clk_i);
			#1;
			t++;
			// a new kind while busy must be ignored
			if (t == 3)
				req_kind_i = sdps_kind_type'(~k);
			if (fz > 0 && t == fz)
				ce_i = 1'b0;
			if (fz > 0 && t == fz + 3)
				ce_i = 1'b1;
			// none of the stock routines multiplexes or steps the address
			if (address_source_select_o !== 2'h0 || next_burst_address_o !== 1'b0)
				am++;
			if (transfer_acknowledge_o === 1'b1) begin
				if (na > 0)
					check(t - la, 4);
				na++;
				la = t;
				if (fa == 0)
					fa = t;
			end
		end
		req_valid_i = 1'b0;
		check(t, len);
		check({busy_o, done_o}, 2'b01);
		check(na, acks);
		check(fa, ack1);
		check(am, 0);
		// one more edge lets the memory see the pins of the last quarter phase
		@(posedge sys_clk_i);
		#1;
		check(cs_lo, cs);
		check(bs_lo, bs);
		check(gp_lo, gp);
		$display("test %s done", nm);
	endtask

	task automatic none_ignored();
		@(posedge sys_clk_i);
		#1;
		req_kind_i = SDPS_KIND_NONE;
		req_valid_i = 1'b1;
		repeat (10) @(posedge sys_clk_i);
		#1;
		check(busy_o, 1'b0);
		req_valid_i = 1'b0;
		$display("test none_ignored done");
	endtask

	task automatic store_write(input logic [5:0] a, input logic [31:0] d);
		@(posedge sys_clk_i);
		#1;
		pat_wr_i = '{we: 1'b1, addr: a, data: d};
		@(posedge sys_clk_i);
		#1;
		pat_wr_i = '0;
	endtask

	task automatic reset_mid();
		@(posedge sys_clk_i);
		#1;
		req_kind_i = SDPS_KIND_BREAD;
		req_valid_i = 1'b1;
		repeat (30) @(posedge sys_clk_i);
		#1;
		rst_n_i = 1'b0;
		req_valid_i = 1'b0;
		#1;
		check({busy_o, done_o, transfer_acknowledge_o}, 3'b000);
		check({chip_select_n_o, byte_strobe_n_o}, 2'b11);
		@(posedge sys_clk_i);
		#1;
		rst_n_i = 1'b1;
		$display("test reset_mid done");
	endtask

	task automatic gp_idle();
		gp0_default_i = 1'b0;
		repeat (2) @(posedge sys_clk_i);
		#1;
		check(gp_line0_o, 1'b0);
		gp0_default_i = 1'b1;
		repeat (2) @(posedge sys_clk_i);
		#1;
		check(gp_line0_o, 1'b1);
		$display("test gp_idle done");
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (2) @(posedge sys_clk_i);
		#1;
		rst_n_i = 1'b1;
		run_pat("single_read", SDPS_KIND_SREAD, 24, 1, 21, 12, 12, 4, 0);
		run_pat("burst_read", SDPS_KIND_BREAD, 52, 8, 21, 8, 32, 0, 0);
		run_pat("single_write", SDPS_KIND_SWRITE, 20, 1, 13, 12, 8, 4, 0);
		run_pat("freeze", SDPS_KIND_SREAD, 27, 1, 24, 12, 12, 4, 7);
		none_ignored();
		// end word of single read now runs twice, so one more bus clock and ack
		store_write(6'h04, 32'hF0FF_FD05);
		run_pat("repeat_two", SDPS_KIND_SREAD, 28, 2, 21, 12, 16, 4, 0);
		reset_mid();
		// reset reloads the store, so the plain single read comes back
		run_pat("after_reset", SDPS_KIND_SREAD, 24, 1, 21, 12, 12, 4, 0);
		gp_idle();
		print_verdict();
	end
endmodule

`default_nettype wire
